// file: rtl/sdl_pkg.sv
// package: constants and types shared by both ends of the serial converter link
package sdl_pkg;
    localparam int          FRAME_BITS     = 16;
    localparam int          CODE_BITS      = 12;
    localparam int          MODE_HI_POS    = 13;
    localparam int          MODE_LO_POS    = 12;
    localparam int          CODE_MSB_POS   = 11;
    localparam logic [11:0] CODE_RESET     = 12'h000;
    localparam logic [4:0]  BIT_CNT_RESET  = 5'h00;
    // apb register byte offsets of the controller
    localparam logic [3:0]  OFS_DATA       = 4'h0;
    localparam logic [3:0]  OFS_CTRL       = 4'h4;
    localparam logic [3:0]  OFS_STATUS     = 4'h8;
    // timing
    localparam int          PCLK_MHZ       = 40;
    localparam int          SYNC_HIGH_NS   = 33;
    localparam int          SYNC_HIGH_CYC  = (SYNC_HIGH_NS * PCLK_MHZ + 999) / 1000;
    localparam int          WAKE_5V_NS     = 2500;
    localparam int          WAKE_3V_NS     = 5000;
    localparam int          LINK_MAX_MHZ   = 30;
    localparam int          SCLK_DIV_DEF   = 2;
    typedef enum logic [1:0] {
        SDL_MODE_NORMAL,
        SDL_MODE_PD_1K,
        SDL_MODE_PD_100K,
        SDL_MODE_PD_HIZ
    } sdl_mode_t;
endpackage

// file: rtl/sdl_link_if.sv
// interface: three-wire write-only link between controller and converter
interface sdl_link_if;
    logic sync_n;
    logic sclk;
    logic din;
    modport host (output sync_n, output sclk, output din);
    modport dev  (input sync_n, input sclk, input din);
endinterface

// file: rtl/sdl_frame_dev.sv
// module: converter end, loads 16-bit frames from the serial link
// Operation
// - frame starts at select falling or after reset
// - sample data on falling shift clock
// - execute frame on sixteenth falling edge
// - new frame needs fresh select fall
// - host holds select high 33ns
// - host may park select low
// - frame: ignore, mode bits, code
// - host sends most significant first
// - early select rise clears shifter
// - abort keeps code and mode
// - reset clears code to zero
// - decode mode bits to four modes
// - 1k and 100k power-down swap output for termination
// - power-down keeps stored code
// - output valid after wake delay
// - code is straight binary
// - shift clock at most 30MHz
module sdl_frame_dev
    import sdl_pkg::*;
#(
    parameter int WAKE_CYC = 75
) (
    sdl_link_if.dev                    link,
    input  wire logic                  presetn,
    output logic [sdl_pkg::CODE_BITS-1:0] code_out,
    output sdl_pkg::sdl_mode_t         mode_out,
    output logic                       amp_on,
    output logic                       term_1k,
    output logic                       term_100k,
    output logic                       out_valid
);
    import sdl_pkg::*;

    // ****************************************
    // input shifter, on falling shift clock
    // ****************************************
    logic [FRAME_BITS-2:0] shift_r;
    logic [4:0]            cnt_r;
    logic                  armed_r;
    logic [CODE_BITS-1:0]  code_r;
    sdl_mode_t             mode_r;
    wire  logic [FRAME_BITS-1:0] frame_w = {shift_r, link.din};
    wire  logic            last_w = (cnt_r == 5'(FRAME_BITS - 1));
    wire  logic            exec_w = !link.sync_n && armed_r && last_w;
    // power-down frames keep the stored code; only a normal-mode frame loads a new one
    wire  logic            normal_w = (frame_w[MODE_HI_POS:MODE_LO_POS] == 2'b00);

    // select high acts as asynchronous clear: abort and re-arm
    always_ff @(negedge link.sclk or posedge link.sync_n or negedge presetn) begin
        if (!presetn) begin
            shift_r <= '0;
            cnt_r   <= BIT_CNT_RESET;
            // power-up counts as select high; a reset inside a frame accepts its tail
            armed_r <= 1'b1;
        end else if (link.sync_n) begin
            shift_r <= '0;
            cnt_r   <= BIT_CNT_RESET;
            armed_r <= 1'b1;
        end else if (armed_r) begin
            shift_r <= frame_w[FRAME_BITS-2:0];
            cnt_r   <= cnt_r + 5'h01;
            if (last_w) begin
                armed_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // code and mode, loaded only on completion
    // ****************************************
    always_ff @(negedge link.sclk or negedge presetn) begin
        if (!presetn) begin
            code_r <= CODE_RESET;
            mode_r <= SDL_MODE_NORMAL;
        end else if (exec_w) begin
            if (normal_w) begin
                code_r <= frame_w[CODE_MSB_POS:0];
            end
            mode_r <= sdl_mode_t'(frame_w[MODE_HI_POS:MODE_LO_POS]);
        end
    end

    // ****************************************
    // output stage and wake-up timer
    // ****************************************
    // counted on the link clock; stops when the host idles it, so valid waits
    logic [15:0] wake_r;
    always_ff @(negedge link.sclk or negedge presetn) begin
        if (!presetn) begin
            wake_r <= '0;
        end else if (mode_r != SDL_MODE_NORMAL) begin
            wake_r <= 16'(WAKE_CYC);
        end else if (wake_r != 16'h0000) begin
            wake_r <= wake_r - 16'h0001;
        end
    end

    always_comb begin
        code_out  = code_r;
        mode_out  = mode_r;
        amp_on    = (mode_r == SDL_MODE_NORMAL);
        term_1k   = (mode_r == SDL_MODE_PD_1K);
        term_100k = (mode_r == SDL_MODE_PD_100K);
        out_valid = amp_on && (wake_r == 16'h0000);
    end
endmodule

// file: rtl/sdl_host.sv
// module: controller end, APB slave that sends frames over the link
//
// Design decisions made here: the address map and the APB interface to the registers.
module sdl_host
    import sdl_pkg::*;
#(
    parameter int SCLK_DIV = sdl_pkg::SCLK_DIV_DEF
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [3:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    sdl_link_if.host         link
);
    import sdl_pkg::*;

    // ****************************************
    // apb registers
    // ****************************************
    logic [15:0] data_r;
    logic        park_low_r;
    logic        busy_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    // one wait state, so data and refusal stand settled at the completing edge
    wire  logic  acc_w  = psel && penable;
    wire  logic  done_w = acc_w && pready_r;
    wire  logic  wr_w   = done_w && pwrite;
    wire  logic  hit_w  = (paddr == OFS_DATA) || (paddr == OFS_CTRL) || (paddr == OFS_STATUS);
    wire  logic  bad_w  = !hit_w || (pwrite && (paddr == OFS_DATA) && busy_r);
    // refusal is decided a cycle ahead; a frame ending meanwhile must not let it in
    wire  logic  send_w = wr_w && (paddr == OFS_DATA) && !pslverr_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r     <= '0;
            park_low_r <= 1'b0;
            prdata_r   <= '0;
            pready_r   <= 1'b0;
            pslverr_r  <= 1'b0;
        end else begin
            if (send_w) data_r <= pwdata[15:0];
            if (wr_w && paddr == OFS_CTRL) park_low_r <= pwdata[0];
            pready_r  <= acc_w && !pready_r;
            pslverr_r <= acc_w && !pready_r && bad_w;
            prdata_r  <= (paddr == OFS_DATA) ? {16'h0000, data_r} :
                         (paddr == OFS_CTRL) ? {31'h0, park_low_r} :
                         (paddr == OFS_STATUS) ? {31'h0, busy_r} : 32'h0000_0000;
        end
    end
    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    // ****************************************
    // link sequencer
    // ****************************************
    typedef enum {ST_IDLE, ST_GAP, ST_SHIFT, ST_END} sdl_hst_t;
    sdl_hst_t    st_r;
    logic [7:0]  div_r;
    logic [4:0]  bit_r;
    logic        sclk_r, sync_n_r, din_r;
    logic [15:0] sh_r;
    wire  logic  tick_w = (div_r == 8'(SCLK_DIV - 1));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r     <= ST_IDLE;
            div_r    <= '0;
            bit_r    <= '0;
            busy_r   <= 1'b0;
            sclk_r   <= 1'b1;
            sync_n_r <= 1'b1;
            din_r    <= 1'b0;
            sh_r     <= '0;
        end else begin
            div_r <= tick_w ? 8'h00 : div_r + 8'h01;
            case (st_r)
                ST_IDLE: begin
                    // park level moves only at a frame end, so it never makes an empty frame
                    if (send_w) begin
                        busy_r <= 1'b1;
                        sh_r   <= pwdata[15:0];
                        sync_n_r <= 1'b1;
                        bit_r  <= 5'(SYNC_HIGH_CYC);
                        div_r  <= '0;
                        st_r   <= ST_GAP;
                    end
                end
                ST_GAP: begin
                    if (bit_r != 5'h00) bit_r <= bit_r - 5'h01;
                    else begin
                        sync_n_r <= 1'b0;
                        din_r    <= sh_r[15];
                        sh_r     <= {sh_r[14:0], 1'b0};
                        bit_r    <= 5'(FRAME_BITS);
                        st_r     <= ST_SHIFT;
                    end
                end
                ST_SHIFT: if (tick_w) begin
                    sclk_r <= !sclk_r;
                    if (sclk_r) bit_r <= bit_r - 5'h01;
                    else if (bit_r != 5'h00) begin
                        din_r <= sh_r[15];
                        sh_r  <= {sh_r[14:0], 1'b0};
                    end else st_r <= ST_END;
                end
                ST_END: begin
                    sync_n_r <= !park_low_r;
                    busy_r   <= 1'b0;
                    st_r     <= ST_IDLE;
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    assign link.sclk   = sclk_r;
    assign link.sync_n = sync_n_r;
    assign link.din    = din_r;
endmodule

// file: verif/sdl_link_asserts.sv
// checker: link framing and converter output properties
module sdl_link_asserts
    import sdl_pkg::*;
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              sync_n,
    input wire logic              sclk,
    input wire logic              din,
    input wire logic [11:0]       code_out,
    input wire sdl_pkg::sdl_mode_t mode_out,
    input wire logic              amp_on,
    input wire logic              term_1k,
    input wire logic              term_100k,
    input wire logic              out_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic        sclk_r;
    logic [4:0]  cnt_r;
    logic [14:0] sh_r;
    // shift clock comes from pclk flops, so sampling on pclk sees every edge
    wire         fall = sclk_r & ~sclk & ~sync_n;
    wire  [15:0] word = {sh_r, din};
    wire         exec = fall && cnt_r == 5'h0F;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_r <= 1'b1;
            cnt_r  <= 5'h00;
        end else begin
            sclk_r <= sclk;
            cnt_r  <= sync_n ? 5'h00 : cnt_r + 5'(fall);
        end
    end
    always_ff @(posedge pclk) begin
        if (fall) begin
            sh_r <= word[14:0];
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_sync_gap: assert property ($rose(sync_n) |-> sync_n[*2])
        else $error("select high too briefly");
    a_frame_len: assert property ($rose(sync_n) |-> cnt_r == 5'h10)
        else $error("frame not sixteen edges");
    a_start_edge: assert property ($fell(sync_n) |-> sclk && cnt_r == 5'h00)
        else $error("frame started badly");
    a_exec_load: assert property (exec |-> {mode_out, code_out} ==
        {word[13:12], (|word[13:12]) ? $past(code_out) : word[11:0]})
        else $error("frame not executed on last edge");
    a_state_hold: assert property ($changed({mode_out, code_out}) && $past(presetn) |-> exec)
        else $error("state changed outside execution");
    a_term_sel: assert property ({amp_on, term_1k, term_100k} ==
        {mode_out == SDL_MODE_NORMAL, mode_out == SDL_MODE_PD_1K, mode_out == SDL_MODE_PD_100K})
        else $error("termination does not match mode");
    a_pd_invalid: assert property (mode_out != SDL_MODE_NORMAL |-> !out_valid)
        else $error("output valid in power-down");
    a_sclk_half: assert property ($changed(sclk) |=> $stable(sclk))
        else $error("shift clock too fast");
endmodule

// file: verif/serial_dac_frame_loader_tb_top.sv
// testbench: controller driving a converter, plus a bench-driven converter
module serial_dac_frame_loader_tb_top
    import sdl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [3:0]  paddr = 4'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'hDF57;
    logic        pready, pslverr, err, amp1, t1k, t100k, val1;
    logic [11:0] code1, code2;
    sdl_mode_t   mode1, mode2;
    int          bad_count = 0, comparisons = 0, m_code = 0, m_mode = 0;
    logic [15:0] q[$];
    sdl_link_if  lk();
    sdl_link_if  lk2();
    always #12.5 pclk = ~pclk;
    sdl_host i_sdl_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(lk.host));
    sdl_frame_dev #(.WAKE_CYC(20)) i_sdl_frame_dev (.link(lk.dev), .presetn(presetn),
        .code_out(code1), .mode_out(mode1), .amp_on(amp1), .term_1k(t1k),
        .term_100k(t100k), .out_valid(val1));
    sdl_frame_dev #(.WAKE_CYC(20)) i_sdl_frame_dev_b (.link(lk2.dev), .presetn(presetn),
        .code_out(code2), .mode_out(mode2), .amp_on(), .term_1k(), .term_100k(), .out_valid());
    sdl_link_asserts u_chk (.pclk(pclk), .presetn(presetn), .sync_n(lk.sync_n),
        .sclk(lk.sclk), .din(lk.din), .code_out(code1), .mode_out(mode1), .amp_on(amp1),
        .term_1k(t1k), .term_100k(t100k), .out_valid(val1));
    // ****************
    // tasks
    // ****************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input bit ok, input string m);
        comparisons++;
        if (!ok) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, m);
        end
    endtask
    task automatic apb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task automatic frame(input logic [15:0] f, input logic p);
        apb(1'b1, OFS_DATA, {16'h0000, f});
        chk(err === 1'b0, "data write refused");
        apb(1'b1, OFS_DATA, 32'h0);
        chk(err === 1'b1, "write taken while busy");
        m_mode = f[13:12];
        if (m_mode == 0) m_code = f[11:0];
        for (int i = 0; i < 100; i++) begin
            apb(1'b0, OFS_STATUS, 32'h0);
            if (rd[0] === 1'b0) break;
        end
        chk(code1 === 12'(m_code) && mode1 === sdl_mode_t'(m_mode), "frame result");
        chk(lk.sync_n === ~p, "select idle level");
    endtask
    // bench drives the second link with a 30 ns shift clock, data on rising edges
    task automatic lk2f(input logic [15:0] f, input int n, input logic fresh, input logic keep);
        if (fresh) begin
            lk2.sync_n = 1'b1;
            #45;
        end
        lk2.sync_n = 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            lk2.din = f[i];
            #15 lk2.sclk = 1'b0;
            #15 lk2.sclk = 1'b1;
        end
        lk2.din = ~lk2.din;
        lk2.sync_n = keep;
        #45;
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        {lk2.sync_n, lk2.sclk, lk2.din} = 3'b110;
        // falls at time zero so every asynchronous reset sees an edge
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        chk(code1 === 12'h000 && mode1 === SDL_MODE_NORMAL, "reset state");
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(rd === 32'h0, "status reset value");
        apb(1'b0, 4'hC, 32'h0);
        chk(err === 1'b1 && rd === 32'h0, "unmapped access");
        q = '{16'hCFFF, 16'h0000};
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            q.push_back({seed[15:14], 2'(k), seed[11:0]});
        end
        foreach (q[i]) begin
            if (i == 5) begin
                apb(1'b1, OFS_CTRL, 32'h1);
                apb(1'b0, OFS_CTRL, 32'h0);
                chk(rd[0] === 1'b1, "park readback");
            end
            frame(q[i], i >= 5);
        end
        lk2f(16'h0ABC, 16, 1'b1, 1'b0);
        lk2f(16'h0123, 15, 1'b1, 1'b1);
        chk(code2 === 12'hABC && mode2 === SDL_MODE_NORMAL, "abort changed state");
        lk2f(16'h2456, 16, 1'b1, 1'b0);
        lk2f(16'h0000, 16, 1'b0, 1'b0);
        chk(code2 === 12'hABC && mode2 === SDL_MODE_PD_100K, "edges after execution");
        lk2f(16'h0FFF, 16, 1'b1, 1'b0);
        chk(code2 === 12'hFFF && mode2 === SDL_MODE_NORMAL, "fresh frame");
        report_and_stop();
    end
endmodule
